/* File: rtl/flash_cmd_consts.vh */
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_IDENT_READ 8'h9F
`define OP_MAKER_PART_READ 8'h90
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_SECTOR_WIPE_A 8'h20
`define OP_SECTOR_WIPE_B 8'hD8
`define OP_ARRAY_ERASE_A 8'hC7
`define OP_ARRAY_ERASE_B 8'h60
`define OP_PAGE_WRITE 8'h02
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_PAR_ENTRY 8'h55
`define OP_PAR_EXIT 8'h45
`define OP_SLEEP_ENTRY 8'hB9
`define OP_SLEEP_RELEASE 8'hAB
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_BUSY 0
`define ST_WEL 1
`define ST_BP_LO 2
`define ST_BP_HI 5
`define ST_RESET 8'h00
// ----------------------------------------
// Framing and timing
// ----------------------------------------
`define BYTE_BITS 4'd8
`define DUMMY_BYTES_RES 3'd3
`define ARRAY_WIPE_TIME_US 1000
`define SLEEP_ENTRY_DELAY_US 3
`define SLEEP_EXIT_DELAY_US 30
`define CLK_MHZ 25
`define SECTOR_WIPE_TIME_US 500
`define PAGE_WRITE_TIME_US 100
`define STATUS_WRITE_TIME_US 50
`endif

/* File: rtl/serial_flash_erase_powerdown_cmds.v */
// Function
// - Erase needs write enable; sets array ones.
// - Erase opcode C7h, also 60h on small sectors.
// - Erase only when select rises after bit eight.
// - Erase timed; busy while running; latch cleared.
// - Erase refused if any protect bit set.
// - Sleep entry needs exact eight-bit frame; delayed.
// - In deep sleep only release opcode obeyed.
// - Reset always wakes into standby.
// - Sleep entry refused while operation busy.
// - Standby when deselected, not busy, not in deep sleep or its exit delay.
// - Release byte alone wakes after exit delay.
// - Release plus three dummies shifts signature out.
// - Signature equals device part of identifier.
// - Signature repeats each byte until deselect.
// - Ident reads end in standby at deselect.
// - Parallel mode outputs one byte per clock.
// - Parallel mode entered by 55h, left 45h.
// - Read, fast read, ident read framing decoded.
// - Maker read, write enable/disable decoded.
// - Sector wipe and page write decoded.
// - Status read and status write decoded.
// - Status write needs write enable latch set.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.vh"
module serial_flash_erase_powerdown_cmds #(
  parameter BIG_SECTORS = 0,
  parameter [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
  parameter [7:0] MAKER_ID = 8'hA5, // Arbitrary value
  parameter [7:0] CAP_ID = 8'h18, // Arbitrary value
  parameter integer WIPE_CYCLES = `ARRAY_WIPE_TIME_US * `CLK_MHZ,
  parameter integer SECTOR_CYCLES = `SECTOR_WIPE_TIME_US * `CLK_MHZ,
  parameter integer PAGE_CYCLES = `PAGE_WRITE_TIME_US * `CLK_MHZ,
  parameter integer SRW_CYCLES = `STATUS_WRITE_TIME_US * `CLK_MHZ,
  parameter integer SLEEP_IN_CYCLES = `SLEEP_ENTRY_DELAY_US * `CLK_MHZ,
  parameter integer SLEEP_OUT_CYCLES = `SLEEP_EXIT_DELAY_US * `CLK_MHZ
) (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire [7:0] par_in,
  output reg so,
  output reg so_oe,
  output reg [7:0] parallel_out_bus,
  output reg parallel_oe,
  output reg [7:0] status,
  output reg deep_sleep,
  output reg standby,
  output reg parallel_mode,
  output reg erase_start,
  output reg [1:0] erase_kind,
  output reg [23:0] op_addr,
  output reg prog_byte_valid,
  output reg [7:0] prog_byte,
  output reg read_active,
  output reg [7:0] last_opcode
);

// ----------------------------------------
// Pin synchronisers and edge detection
// ----------------------------------------
reg cs_m, cs_s, cs_d;
reg sck_m, sck_s, sck_d;
reg si_m, si_s;
reg [7:0] par_m, par_s;
always @(posedge clk) begin
  if (sys_rst) begin
    cs_m <= 1'b1; cs_s <= 1'b1; cs_d <= 1'b1;
    sck_m <= 1'b0; sck_s <= 1'b0; sck_d <= 1'b0;
    si_m <= 1'b0; si_s <= 1'b0;
    par_m <= 8'h00; par_s <= 8'h00;
  end else if (clk_en) begin
    cs_m <= cs_n; cs_s <= cs_m; cs_d <= cs_s;
    sck_m <= sck; sck_s <= sck_m; sck_d <= sck_s;
    si_m <= si; si_s <= si_m;
    par_m <= par_in; par_s <= par_m;
  end
end
wire sel = ~cs_s;
wire cs_rise = cs_s & ~cs_d;
wire sck_rise = sel & sck_s & ~sck_d;
wire sck_fall = sel & ~sck_s & sck_d;

// ----------------------------------------
// Frame phases, one-hot
// ----------------------------------------
localparam PH_OP = 6'b000001;
localparam PH_ADDR = 6'b000010;
localparam PH_DUMMY = 6'b000100;
localparam PH_DATA_IN = 6'b001000;
localparam PH_DATA_OUT = 6'b010000;
localparam PH_IGNORE = 6'b100000;

function is_op;
  input [7:0] op;
  input [7:0] code;
  begin
    is_op = (op == code);
  end
endfunction

reg [5:0] phase;
reg [7:0] shift_in;
reg [3:0] bit_cnt;
reg [2:0] byte_cnt;
reg [7:0] opcode;
reg [7:0] out_byte;
reg [2:0] out_bit;
reg [1:0] id_idx;
reg frame_bad;
reg [31:0] busy_cnt;
reg [31:0] sleep_cnt;
reg sleep_pending_in, sleep_pending_out;
reg [1:0] busy_kind;

wire busy = status[`ST_BUSY];
wire write_enable_latch = status[`ST_WEL];
wire bp_clear = (status[`ST_BP_HI:`ST_BP_LO] == 4'h0);
wire byte_done_s = (bit_cnt == `BYTE_BITS - 4'd1);
wire [7:0] byte_now = parallel_mode ? par_s : {shift_in[6:0], si_s};
wire byte_done = parallel_mode | byte_done_s;
wire [7:0] sig_byte = DEVICE_ID;

function [7:0] ident_byte;
  input [1:0] idx;
  input [7:0] op;
  input [7:0] st;
  begin
    if (op == `OP_IDENT_READ)
      ident_byte = (idx == 2'd0) ? MAKER_ID : (idx == 2'd1) ? DEVICE_ID : CAP_ID;
    else if (op == `OP_MAKER_PART_READ)
      ident_byte = idx[0] ? DEVICE_ID : MAKER_ID;
    else if (op == `OP_STATUS_READ)
      ident_byte = st;
    else
      ident_byte = sig_byte;
  end
endfunction
wire [7:0] out_fetch = ident_byte(id_idx, opcode, status);

// Opcodes accepted at the end of the first byte
function op_known;
  input [7:0] op;
  begin
    op_known = is_op(op, `OP_READ) | is_op(op, `OP_FAST_READ) |
      is_op(op, `OP_IDENT_READ) | is_op(op, `OP_MAKER_PART_READ) |
      is_op(op, `OP_WRITE_ENABLE) | is_op(op, `OP_WRITE_DISABLE) |
      is_op(op, `OP_SECTOR_WIPE_B) | is_op(op, `OP_ARRAY_ERASE_A) |
      (!BIG_SECTORS && (is_op(op, `OP_SECTOR_WIPE_A) | is_op(op, `OP_ARRAY_ERASE_B))) |
      is_op(op, `OP_PAGE_WRITE) | is_op(op, `OP_STATUS_READ) |
      is_op(op, `OP_STATUS_WRITE) | is_op(op, `OP_PAR_ENTRY) |
      is_op(op, `OP_PAR_EXIT) | is_op(op, `OP_SLEEP_ENTRY) |
      is_op(op, `OP_SLEEP_RELEASE);
  end
endfunction

// ----------------------------------------
// Command engine
// ----------------------------------------
always @(posedge clk) begin
  if (sys_rst) begin
    phase <= PH_OP;
    shift_in <= 8'h00;
    bit_cnt <= 4'd0;
    byte_cnt <= 3'd0;
    opcode <= 8'h00;
    out_byte <= 8'h00;
    out_bit <= 3'd0;
    id_idx <= 2'd0;
    frame_bad <= 1'b0;
    busy_cnt <= 32'd0;
    busy_kind <= 2'd0;
    sleep_cnt <= 32'd0;
    sleep_pending_in <= 1'b0;
    sleep_pending_out <= 1'b0;
    so <= 1'b0;
    so_oe <= 1'b0;
    parallel_out_bus <= 8'h00;
    parallel_oe <= 1'b0;
    status <= `ST_RESET;
    deep_sleep <= 1'b0;
    standby <= 1'b1;
    parallel_mode <= 1'b0;
    erase_start <= 1'b0;
    erase_kind <= 2'd0;
    op_addr <= 24'h000000;
    prog_byte_valid <= 1'b0;
    prog_byte <= 8'h00;
    read_active <= 1'b0;
    last_opcode <= 8'h00;
  end else if (clk_en) begin
    erase_start <= 1'b0;
    prog_byte_valid <= 1'b0;
    // Entry delay still counts as standby; deep sleep and its exit do not
    standby <= cs_s & ~busy & ~deep_sleep & ~sleep_pending_out;
    // Internal timed operation
    if (busy) begin
      if (busy_cnt <= 32'd1) begin
        status[`ST_BUSY] <= 1'b0;
        busy_cnt <= 32'd0;
      end else begin
        busy_cnt <= busy_cnt - 32'd1;
        if (busy_cnt == 32'd2)
          status[`ST_WEL] <= 1'b0;
      end
    end
    // Sleep entry and exit delays
    if (sleep_pending_in | sleep_pending_out) begin
      if (sleep_cnt <= 32'd1) begin
        if (sleep_pending_in)
          deep_sleep <= 1'b1;
        else
          deep_sleep <= 1'b0;
        sleep_pending_in <= 1'b0;
        sleep_pending_out <= 1'b0;
        sleep_cnt <= 32'd0;
      end else
        sleep_cnt <= sleep_cnt - 32'd1;
    end
    if (cs_rise) begin
      so_oe <= 1'b0;
      parallel_oe <= 1'b0;
      read_active <= 1'b0;
      if (phase == PH_DATA_OUT || phase == PH_IGNORE) begin
        phase <= PH_OP;
      end else begin
        // Frames that execute on deselect
        if (phase == PH_ADDR && byte_cnt == 3'd0 && bit_cnt == 4'd0 && !frame_bad) begin
          if (deep_sleep && !is_op(opcode, `OP_SLEEP_RELEASE)) begin
          end else if (is_op(opcode, `OP_ARRAY_ERASE_A) ||
                       (!BIG_SECTORS && is_op(opcode, `OP_ARRAY_ERASE_B))) begin
            if (write_enable_latch && bp_clear && !busy) begin
              status[`ST_BUSY] <= 1'b1;
              busy_cnt <= WIPE_CYCLES;
              erase_start <= 1'b1;
              erase_kind <= 2'd1;
            end
          end else if (is_op(opcode, `OP_SLEEP_ENTRY)) begin
            if (!busy) begin
              sleep_pending_in <= 1'b1;
              sleep_cnt <= SLEEP_IN_CYCLES;
            end
          end else if (is_op(opcode, `OP_SLEEP_RELEASE)) begin
            if (deep_sleep || sleep_pending_in) begin
              sleep_pending_in <= 1'b0;
              sleep_pending_out <= 1'b1;
              sleep_cnt <= SLEEP_OUT_CYCLES;
            end
          end else if (is_op(opcode, `OP_WRITE_ENABLE) && !busy) begin
            status[`ST_WEL] <= 1'b1;
          end else if (is_op(opcode, `OP_WRITE_DISABLE) && !busy) begin
            status[`ST_WEL] <= 1'b0;
          end else if (is_op(opcode, `OP_PAR_ENTRY)) begin
            parallel_mode <= 1'b1;
          end else if (is_op(opcode, `OP_PAR_EXIT)) begin
            parallel_mode <= 1'b0;
          end
        end else if (phase == PH_DATA_IN && bit_cnt == 4'd0 && byte_cnt != 3'd0 &&
                     !busy && write_enable_latch) begin
          if (is_op(opcode, `OP_PAGE_WRITE)) begin
            status[`ST_BUSY] <= 1'b1;
            busy_cnt <= PAGE_CYCLES;
            erase_kind <= 2'd3;
          end else if (is_op(opcode, `OP_STATUS_WRITE) && byte_cnt == 3'd1) begin
            status[`ST_BP_HI:`ST_BP_LO] <= shift_in[`ST_BP_HI:`ST_BP_LO];
            status[7:6] <= shift_in[7:6];
            status[`ST_BUSY] <= 1'b1;
            busy_cnt <= SRW_CYCLES;
          end
        end else if (phase == PH_DUMMY && byte_cnt == 3'd0 && bit_cnt == 4'd0 &&
                     (is_op(opcode, `OP_SECTOR_WIPE_A) || is_op(opcode, `OP_SECTOR_WIPE_B)) &&
                     !busy && write_enable_latch) begin
          status[`ST_BUSY] <= 1'b1;
          busy_cnt <= SECTOR_CYCLES;
          erase_start <= 1'b1;
          erase_kind <= 2'd2;
        end
        phase <= PH_OP;
      end
      bit_cnt <= 4'd0;
      byte_cnt <= 3'd0;
      frame_bad <= 1'b0;
      id_idx <= 2'd0;
    end else if (sck_rise) begin
      shift_in <= byte_now;
      bit_cnt <= byte_done ? 4'd0 : bit_cnt + 4'd1;
      case (phase)
        PH_OP: begin
          if (byte_done) begin
            opcode <= byte_now;
            last_opcode <= byte_now;
            byte_cnt <= 3'd0;
            if (!op_known(byte_now) ||
                (deep_sleep && !is_op(byte_now, `OP_SLEEP_RELEASE)))
              phase <= PH_IGNORE;
            else if (is_op(byte_now, `OP_STATUS_READ) || is_op(byte_now, `OP_IDENT_READ)) begin
              phase <= PH_DATA_OUT;
              read_active <= 1'b1;
            end else
              phase <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          // Bytes after a no-address opcode other than status write spoil its frame
          if (byte_done) begin
            op_addr <= {op_addr[15:0], byte_now};
            byte_cnt <= byte_cnt + 3'd1;
            if (is_op(opcode, `OP_SLEEP_RELEASE)) begin
              byte_cnt <= 3'd0;
              phase <= (byte_cnt == `DUMMY_BYTES_RES - 3'd1) ? PH_DATA_OUT : PH_DUMMY;
              frame_bad <= 1'b1;
              if (byte_cnt == `DUMMY_BYTES_RES - 3'd1) begin
                read_active <= 1'b1;
                if (deep_sleep || sleep_pending_in) begin
                  sleep_pending_in <= 1'b0;
                  sleep_pending_out <= 1'b1;
                  sleep_cnt <= SLEEP_OUT_CYCLES;
                end
              end else
                byte_cnt <= byte_cnt + 3'd1;
            end else if (is_op(opcode, `OP_STATUS_WRITE)) begin
              shift_in <= byte_now;
              byte_cnt <= 3'd1;
              phase <= PH_DATA_IN;
            end else if (byte_cnt == 3'd2) begin
              byte_cnt <= 3'd0;
              if (is_op(opcode, `OP_PAGE_WRITE))
                phase <= PH_DATA_IN;
              else if (is_op(opcode, `OP_FAST_READ))
                phase <= PH_DUMMY;
              else if (is_op(opcode, `OP_READ) || is_op(opcode, `OP_MAKER_PART_READ)) begin
                phase <= PH_DATA_OUT;
                read_active <= 1'b1;
              end else if (is_op(opcode, `OP_SECTOR_WIPE_A) || is_op(opcode, `OP_SECTOR_WIPE_B))
                phase <= PH_DUMMY;
              else
                phase <= PH_IGNORE;
            end else if (byte_cnt == 3'd0 && !(is_op(opcode, `OP_READ) ||
                         is_op(opcode, `OP_FAST_READ) || is_op(opcode, `OP_PAGE_WRITE) ||
                         is_op(opcode, `OP_MAKER_PART_READ) || is_op(opcode, `OP_SECTOR_WIPE_A) ||
                         is_op(opcode, `OP_SECTOR_WIPE_B)))
              phase <= PH_IGNORE;
          end
        end
        PH_DUMMY: begin
          if (byte_done) begin
            if (is_op(opcode, `OP_SLEEP_RELEASE)) begin
              byte_cnt <= byte_cnt + 3'd1;
              if (byte_cnt == `DUMMY_BYTES_RES - 3'd1) begin
                phase <= PH_DATA_OUT;
                read_active <= 1'b1;
                if (deep_sleep || sleep_pending_in) begin
                  sleep_pending_in <= 1'b0;
                  sleep_pending_out <= 1'b1;
                  sleep_cnt <= SLEEP_OUT_CYCLES;
                end
              end
            end else if (is_op(opcode, `OP_FAST_READ)) begin
              phase <= PH_DATA_OUT;
              read_active <= 1'b1;
            end else
              phase <= PH_IGNORE; // Sector wipe takes no more bytes
          end
        end
        PH_DATA_IN: begin
          if (byte_done) begin
            prog_byte <= byte_now;
            prog_byte_valid <= is_op(opcode, `OP_PAGE_WRITE);
            if (byte_cnt != 3'd7)
              byte_cnt <= byte_cnt + 3'd1;
            if (is_op(opcode, `OP_STATUS_WRITE))
              phase <= PH_IGNORE; // Exactly one data byte
          end
        end
        PH_DATA_OUT: begin
        end
        PH_IGNORE: begin
        end
        default: phase <= PH_IGNORE;
      endcase
    end else if (sck_fall && phase == PH_DATA_OUT) begin
      if (parallel_mode) begin
        parallel_out_bus <= out_fetch;
        parallel_oe <= 1'b1;
        id_idx <= id_idx + 2'd1;
      end else begin
        if (out_bit == 3'd0 || !so_oe) begin
          out_byte <= {out_fetch[6:0], 1'b0};
          so <= out_fetch[7];
          id_idx <= id_idx + 2'd1;
          out_bit <= 3'd7;
        end else begin
          so <= out_byte[7];
          out_byte <= {out_byte[6:0], 1'b0};
          out_bit <= out_bit - 3'd1;
        end
        so_oe <= 1'b1;
      end
    end
    if (cs_rise)
      out_bit <= 3'd0;
  end
end

endmodule // serial_flash_erase_powerdown_cmds
`default_nettype wire

/* File: sim/flash_cmd_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_chk #(
  parameter integer WIPE_CYCLES = 200
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic parallel_oe,
  input wire logic [7:0] status,
  input wire logic deep_sleep,
  input wire logic standby,
  input wire logic parallel_mode,
  input wire logic erase_start,
  input wire logic [1:0] erase_kind,
  input wire logic [7:0] last_opcode
);
  // ----
  // Busy length counter
  // ----
  logic [31:0] bcnt;
  always_ff @(posedge clk) begin
    if (sys_rst || !status[0]) begin
      bcnt <= 32'h0;
    end else begin
      bcnt <= bcnt + 32'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst || !clk_en);
  a_erase_allowed: assert property (
    erase_start && erase_kind == 2'h1 |-> status[1] && status[5:2] == 4'h0)
    else $error("array erase without latch or with protection");
  a_erase_opcode: assert property (
    erase_start && erase_kind == 2'h1 |-> last_opcode == 8'hC7 || last_opcode == 8'h60)
    else $error("array erase from a wrong opcode");
  a_busy_follows: assert property (erase_start |-> ##[0:2] status[0])
    else $error("busy not set after erase start");
  a_busy_bounded: assert property (bcnt <= WIPE_CYCLES + 4)
    else $error("busy held too long");
  a_latch_first: assert property ($fell(status[0]) |-> !status[1])
    else $error("write enable latch still set when busy clears");
  a_sleep_idle: assert property ($rose(deep_sleep) |-> !status[0])
    else $error("deep sleep entered while busy");
  a_sleep_inert: assert property (deep_sleep |-> !erase_start)
    else $error("erase started in deep sleep");
  a_idle_standby: assert property (
    (cs_n && !status[0] && !deep_sleep) [*6] |-> standby)
    else $error("no standby while deselected and idle");
  a_select_active: assert property ((!cs_n && !deep_sleep) [*6] |-> !standby)
    else $error("standby while selected");
  a_deselect_quiet: assert property (cs_n [*6] |-> !so_oe)
    else $error("serial output driven while deselected");
  a_par_quiet: assert property (!parallel_mode |-> !parallel_oe)
    else $error("parallel output outside parallel mode");
  cover property (erase_start);
  cover property ($rose(deep_sleep));
  cover property ($rose(so_oe));
  cover property ($rose(parallel_mode));
endmodule // flash_cmd_chk
`default_nettype wire

/* File: sim/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk,
  input wire logic so,
  output var logic cs_n,
  output var logic sck,
  output var logic si,
  output var logic [7:0] par_in
);
  // ----
  // Host frame tasks, serial clock idles low
  // ----
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    par_in = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Eight clocks per bit keeps the serial clock far below 10 MHz
  task automatic xbit(input logic b, output logic q);
    sck = 1'b0;
    si = b;
    tick(4);
    sck = 1'b1;
    tick(4);
    q = so;
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    par_in = d;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
  endtask
  // Parallel mode moves one whole byte per serial clock
  task automatic xpar(input logic [7:0] d);
    sck = 1'b0;
    par_in = d;
    tick(4);
    sck = 1'b1;
    tick(4);
  endtask
  task automatic sel();
    cs_n = 1'b0;
  endtask
  // Deselect right after the last bit; released lines show the inverse
  task automatic desel();
    sck = 1'b0;
    tick(4);
    cs_n = 1'b1;
    si = ~si;
    par_in = ~par_in;
    tick(8);
  endtask
endmodule // spi_host_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam integer WIPE = 200;
  localparam integer SLP_IN = 20;
  localparam integer SLP_OUT = 30;
  localparam logic [7:0] DEV_ID = 8'h3C; // Arbitrary value
  logic clk;
  logic sys_rst;
  logic clk_en;
  logic b;
  logic [7:0] q;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  wire cs_n, sck, si, so, so_oe, parallel_oe, deep_sleep, standby;
  wire parallel_mode, erase_start, prog_byte_valid, read_active;
  wire [7:0] par_in, parallel_out_bus, status, prog_byte, last_opcode;
  wire [1:0] erase_kind;
  wire [23:0] op_addr;
  serial_flash_erase_powerdown_cmds #(
    .DEVICE_ID(DEV_ID), .WIPE_CYCLES(WIPE), .SRW_CYCLES(40), .SLEEP_IN_CYCLES(SLP_IN),
    .SLEEP_OUT_CYCLES(SLP_OUT)
  ) dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cs_n), .sck(sck), .si(si),
    .par_in(par_in), .so(so), .so_oe(so_oe), .parallel_out_bus(parallel_out_bus),
    .parallel_oe(parallel_oe), .status(status), .deep_sleep(deep_sleep),
    .standby(standby), .parallel_mode(parallel_mode), .erase_start(erase_start),
    .erase_kind(erase_kind), .op_addr(op_addr), .prog_byte_valid(prog_byte_valid),
    .prog_byte(prog_byte), .read_active(read_active), .last_opcode(last_opcode)
  );
  spi_host_model host (
    .clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si), .par_in(par_in)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end
  // ----
  // Bench tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rst();
    sys_rst = 1'b1;
    host.tick(4);
    sys_rst = 1'b0;
    host.tick(4);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.xbyte(op, q);
    host.desel();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && status[0] !== 1'b0; i++) begin
      host.tick(1);
    end
  endtask
  task automatic status_write_cmd(input logic [7:0] d);
    host.sel();
    host.xbyte(8'h01, q);
    host.xbyte(d, q);
    host.desel();
    wait_idle();
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    clk_en = 1'b1;
    sys_rst = 1'b1;
    rst();
    chk({5'h00, standby, deep_sleep, parallel_mode}, 8'h04);
    chk(status, 8'h00);
    // A frame sent while the enable is low must leave no trace
    clk_en = 1'b0;
    cmd(8'h06);
    clk_en = 1'b1;
    host.tick(4);
    chk(status, 8'h00);
    cmd(8'hC7);
    chk(status, 8'h00);
    for (int i = 0; i < 2; i++) begin
      cmd(8'h06);
      chk(status, 8'h02);
      cmd(i ? 8'h60 : 8'hC7);
      chk(status, 8'h03);
      wait_idle();
      chk(status, 8'h00);
    end
    cmd(8'h06);
    host.sel();
    host.xbyte(8'hC7, q);
    host.xbit(1'b0, b);
    host.desel();
    chk({7'h00, status[0]}, 8'h00);
    host.sel();
    host.xbyte(8'hFF, q);
    host.xbyte(8'hC7, q);
    host.desel();
    chk({7'h00, status[0]}, 8'h00);
    host.sel();
    host.xbyte(8'h05, q);
    repeat (2) begin
      host.xbyte(8'h00, q);
      chk(q, 8'h02);
    end
    host.desel();
    cmd(8'h04);
    chk(status, 8'h00);
    status_write_cmd(8'h04);
    chk(status, 8'h00);
    cmd(8'h06);
    status_write_cmd(8'h04);
    chk({4'h0, status[5:2]}, 8'h01);
    cmd(8'h06);
    cmd(8'hC7);
    chk({7'h00, status[0]}, 8'h00);
    cmd(8'h06);
    status_write_cmd(8'h00);
    cmd(8'h04);
    chk(status, 8'h00);
    cmd(8'hB9);
    chk({7'h00, deep_sleep}, 8'h00);
    host.tick(SLP_IN + 10);
    chk({7'h00, deep_sleep}, 8'h01);
    cmd(8'h06);
    chk(status, 8'h00);
    cmd(8'hAB);
    chk({7'h00, deep_sleep}, 8'h01);
    host.tick(SLP_OUT + 10);
    chk({6'h00, deep_sleep, standby}, 8'h01);
    cmd(8'h06);
    cmd(8'hC7);
    cmd(8'hB9);
    host.tick(SLP_IN + 10);
    chk({6'h00, deep_sleep, status[0]}, 8'h01);
    wait_idle();
    host.sel();
    host.xbyte(8'hAB, q);
    repeat (3) host.xbyte(8'h00, q);
    repeat (2) begin
      host.xbyte(8'h00, q);
      chk(q, DEV_ID);
    end
    chk({7'h00, read_active}, 8'h01);
    host.desel();
    chk({7'h00, standby}, 8'h01);
    host.sel();
    host.tick(8);
    chk({7'h00, standby}, 8'h00);
    host.desel();
    host.sel();
    host.xbyte(8'h9F, q);
    repeat (2) host.xbyte(8'h00, q);
    chk(q, DEV_ID);
    host.desel();
    host.sel();
    host.xbyte(8'h03, q);
    host.xbyte(8'h12, q);
    host.xbyte(8'h34, q);
    host.xbyte(8'h56, q);
    chk(op_addr[23:16], 8'h12);
    chk(op_addr[7:0], 8'h56);
    chk({7'h00, read_active}, 8'h01);
    host.desel();
    cmd(8'hB9);
    host.tick(SLP_IN + 10);
    rst();
    chk({6'h00, deep_sleep, standby}, 8'h01);
    cmd(8'h55);
    chk({7'h00, parallel_mode}, 8'h01);
    host.sel();
    host.xpar(8'hAB);
    repeat (4) host.xpar(8'h00);
    chk(parallel_out_bus, DEV_ID);
    chk({7'h00, parallel_oe}, 8'h01);
    host.desel();
    host.sel();
    host.xpar(8'h45);
    host.desel();
    chk({7'h00, parallel_mode}, 8'h00);
    cmd(8'h55);
    rst();
    chk({7'h00, parallel_mode}, 8'h00);
    end_of_test();
  end
endmodule // tb_top
bind serial_flash_erase_powerdown_cmds flash_cmd_chk #(.WIPE_CYCLES(WIPE_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cs_n), .so_oe(so_oe),
  .parallel_oe(parallel_oe),
  .status(status), .deep_sleep(deep_sleep), .standby(standby),
  .parallel_mode(parallel_mode), .erase_start(erase_start), .erase_kind(erase_kind),
  .last_opcode(last_opcode)
);
`default_nettype wire
